// [common/nand_host_pkg.sv]
// Shared constants and types for the serial NAND host controller
package nand_host_pkg;

  // Serial clock half period and chip select gap, in system clocks / ticks
  localparam logic [3:0] SCK_HALF_CYC = 4'h4;
  localparam logic [2:0] CS_GAP_TICKS = 3'h4;

  // Register byte offsets
  localparam logic [5:0] REG_CTRL = 6'h00;
  localparam logic [5:0] REG_STATUS = 6'h04;
  localparam logic [5:0] REG_CMD = 6'h08;
  localparam logic [5:0] REG_ADDR = 6'h0C;
  localparam logic [5:0] REG_LEN = 6'h10;
  localparam logic [5:0] REG_CFG = 6'h14;
  localparam logic [5:0] REG_POLL = 6'h18;
  localparam logic [5:0] REG_TXDATA = 6'h1C;
  localparam logic [5:0] REG_RXDATA = 6'h20;

  // Control register write bits
  localparam int CTRL_START = 0;
  localparam int CTRL_CLR_REFUSED = 1;
  localparam int CTRL_ABORT = 2;

  // Busy flag position in the polled status byte
  localparam int STAT_BUSY_BIT = 0;

  // Fast I/O read opcodes
  localparam logic [7:0] OP_DUAL_IO = 8'hBB;
  localparam logic [7:0] OP_DUAL_IO_4B = 8'hBC;
  localparam logic [7:0] OP_QUAD_IO = 8'hEB;
  localparam logic [7:0] OP_QUAD_IO_4B = 8'hEC;

  // Address bytes of the 3-byte and 4-byte read forms
  localparam logic [1:0] COL_BYTES_3 = 2'h2;
  localparam logic [1:0] COL_BYTES_4 = 2'h3;

  // Lane width codes
  localparam logic [1:0] LANE_1 = 2'h0;
  localparam logic [1:0] LANE_2 = 2'h1;
  localparam logic [1:0] LANE_4 = 2'h2;

  // Register reset values
  localparam logic [31:0] CMD_RST = 32'h0000_0000;
  localparam logic [31:0] CFG_RST = 32'h0000_0021;
  localparam logic [31:0] POLL_RST = 32'h0000_0000;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_OPC = 3'b001,
    S_ADDR = 3'b010,
    S_DUMMY = 3'b011,
    S_TXW = 3'b100,
    S_TX = 3'b101,
    S_RX = 3'b110,
    S_GAP = 3'b111
  } state_t;

  typedef struct packed {
    logic [16:0] rsvd;
    logic poll;
    logic addr4;
    logic quad;
    logic fast;
    logic wr;
    logic [1:0] nabytes;
    logic [7:0] opcode;
  } cmd_t;

  typedef struct packed {
    logic [18:0] rsvd;
    logic [4:0] dummy_seq;
    logic [4:0] dummy_buf;
    logic wp_en;
    logic extra;
    logic buf_mode;
  } cfg_t;

  typedef struct packed {
    logic [15:0] rsvd;
    logic [7:0] addr;
    logic [7:0] opcode;
  } poll_t;

  typedef struct packed {
    logic [15:0] rsvd;
    logic [7:0] dev_status;
    logic [3:0] rsvd2;
    logic tx_full;
    logic rx_valid;
    logic refused;
    logic active;
  } stat_t;

  typedef struct packed {
    logic ff1;
    logic ff2;
    logic ff3;
    logic lvl;
  } sync_t;

  typedef struct packed {
    logic [3:0] cnt;
    logic tick;
  } div_t;

  typedef struct packed {
    state_t st;
    logic cs_n;
    logic sck;
    logic [3:0] io_o;
    logic [3:0] io_oe;
    logic wait_r;
    logic [31:0] rdata;
    cmd_t cmd;
    cfg_t cfg;
    poll_t poll;
    logic [23:0] addr;
    logic [15:0] len_r;
    logic [7:0] txd;
    logic tx_full;
    logic [7:0] rxd;
    logic rx_valid;
    logic [7:0] stat;
    logic refused;
    logic [7:0] sh;
    logic [7:0] shin;
    logic [1:0] lane;
    logic [1:0] dl;
    logic [4:0] steps;
    logic [4:0] dum;
    logic [23:0] a24;
    logic [1:0] nab;
    logic [15:0] len;
    logic stream;
    logic xf;
    logic xw;
    logic poll_ph;
    logic abt;
    logic [2:0] gap;
  } host_t;

  localparam host_t HOST_RST = '{
    st: S_IDLE,
    cs_n: 1'b1,
    wait_r: 1'b1,
    cmd: cmd_t'(CMD_RST),
    cfg: cfg_t'(CFG_RST),
    poll: poll_t'(POLL_RST),
    default: '0
  };

endpackage

// [core/nand_io_sync.sv]
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
module nand_io_sync (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Pin and filtered level
  input wire logic pin,
  output logic level
);

  nand_host_pkg::sync_t q;
  nand_host_pkg::sync_t d;

  always_comb
  begin
    d = q;
    d.ff1 = pin;
    d.ff2 = q.ff1;
    d.ff3 = q.ff2;
    // New level only once the last two stages agree
    if (q.ff2 == q.ff3)
    begin
      d.lvl = q.ff3;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign level = q.lvl;

endmodule

// [core/nand_tick_gen.sv]
// Free-running divider giving one tick per serial clock half period
`timescale 1ns/1ns
module nand_tick_gen (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Half-period tick
  output logic tick
);

  nand_host_pkg::div_t q;
  nand_host_pkg::div_t d;

  always_comb
  begin
    d = q;
    d.tick = 1'b0;
    if (q.cnt == nand_host_pkg::SCK_HALF_CYC - 4'h1)
    begin
      d.cnt = 4'h0;
      d.tick = 1'b1;
    end
    else
    begin
      d.cnt = q.cnt + 4'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign tick = q.tick;

endmodule

// [core/nand_host.sv]
// Serial NAND host: fast I/O reads, extra page commands, busy polling
// Behaviour
// - Dual I/O read sends address two lanes
// - 4-byte dual I/O read uses longer address
// - Quad I/O read sends its opcode on one lane, then uses four lanes
// - 4-byte quad I/O read, longer address
// - Set extra access bit before, clear after
// - Page read loads buffer; wait busy clear
// - Extra access forces buffer mode read format
// - OTP program: load buffer, then execute
// - OTP lock: lock bit then execute
// - Protection freeze: lock bit then execute
// - Set protection fields before freezing them
//
// The Avalon-MM interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ns
module nand_host (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Avalon-MM slave
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Serial flash pins
  output logic spi_cs_n,
  output logic spi_sck,
  output logic [3:0] spi_io_o,
  output logic [3:0] spi_io_oe,
  input wire logic [3:0] spi_io_i
);

  nand_host_pkg::host_t q;
  nand_host_pkg::host_t d;
  logic tick;
  logic [3:0] io_in;

  nand_tick_gen u_tick (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .tick(tick)
  );

  generate
    for (genvar i = 0; i < 4; i++)
    begin : g_sync
      nand_io_sync u_sync (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .pin(spi_io_i[i]),
        .level(io_in[i])
      );
    end
  endgenerate

  function automatic logic [31:0] merge(input logic [31:0] cur,
                                        input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = cur;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [23:0] align(input logic [23:0] a,
                                        input logic [1:0] n);
    case (n)
      2'h1: return {a[7:0], 16'h0000};
      2'h2: return {a[15:0], 8'h00};
      default: return a;
    endcase
  endfunction

  function automatic logic [4:0] bsteps(input logic [1:0] lane);
    return 5'(5'h08 >> lane);
  endfunction

  function automatic nand_host_pkg::host_t to_gap(
    input nand_host_pkg::host_t s);
    s.st = nand_host_pkg::S_GAP;
    s.cs_n = 1'b1;
    s.sck = 1'b0;
    s.gap = 3'h0;
    return s;
  endfunction

  always_comb
  begin
    logic req;
    logic ack;
    logic wen;
    logic ctrl_wr;
    logic fast;
    logic bufm;
    logic drv;
    logic [1:0] nab;
    logic [7:0] opc;
    logic [7:0] sin;
    logic [23:0] col;
    logic [31:0] cur;
    logic [31:0] wm;
    nand_host_pkg::stat_t sr;
    req = avs_read | avs_write;
    ack = ~q.wait_r & req;
    wen = ack & avs_write;
    ctrl_wr = wen & avs_byteenable[0]
      & (avs_address == nand_host_pkg::REG_CTRL);
    fast = q.cmd.fast;
    bufm = q.cfg.buf_mode | q.cfg.extra;
    nab = 2'h0;
    opc = 8'h00;
    col = 24'h00_0000;
    drv = 1'b0;
    sr = '0;
    cur = 32'h0000_0000;
    wm = 32'h0000_0000;
    sin = 8'h00;
    sr.dev_status = q.stat;
    sr.tx_full = q.tx_full;
    sr.rx_valid = q.rx_valid;
    sr.refused = q.refused;
    sr.active = (q.st != nand_host_pkg::S_IDLE);
    d = q;

    // Current word of the addressed register
    case (avs_address)
      nand_host_pkg::REG_STATUS: cur = sr;
      nand_host_pkg::REG_CMD: cur = q.cmd;
      nand_host_pkg::REG_ADDR: cur = {8'h00, q.addr};
      nand_host_pkg::REG_LEN: cur = {16'h0000, q.len_r};
      nand_host_pkg::REG_CFG: cur = q.cfg;
      nand_host_pkg::REG_POLL: cur = q.poll;
      nand_host_pkg::REG_TXDATA: cur = {24'h00_0000, q.txd};
      nand_host_pkg::REG_RXDATA: cur = {24'h00_0000, q.rxd};
      default: cur = 32'h0000_0000;
    endcase
    wm = merge(cur, avs_writedata, avs_byteenable);

    // One wait cycle, then the answer
    d.wait_r = ~(q.wait_r & req);
    if (q.wait_r && avs_read)
    begin
      d.rdata = cur;
    end
    if (wen)
    begin
      case (avs_address)
        nand_host_pkg::REG_CMD: d.cmd = nand_host_pkg::cmd_t'(wm);
        nand_host_pkg::REG_ADDR: d.addr = wm[23:0];
        nand_host_pkg::REG_LEN: d.len_r = wm[15:0];
        nand_host_pkg::REG_CFG: d.cfg = nand_host_pkg::cfg_t'(wm);
        nand_host_pkg::REG_POLL: d.poll = nand_host_pkg::poll_t'(wm);
        default: d.rdata = q.rdata;
      endcase
    end
    if (ack && avs_read && avs_address == nand_host_pkg::REG_RXDATA)
    begin
      d.rx_valid = 1'b0;
    end
    if (ctrl_wr && avs_writedata[nand_host_pkg::CTRL_CLR_REFUSED])
    begin
      d.refused = 1'b0;
    end

    // Serial input shift by lane width
    case (q.lane)
      nand_host_pkg::LANE_1: sin = {q.shin[6:0], io_in[1]};
      nand_host_pkg::LANE_2: sin = {q.shin[5:0], io_in[1:0]};
      default: sin = {q.shin[3:0], io_in};
    endcase

    unique case (q.st)
      nand_host_pkg::S_IDLE:
      begin
        if (ctrl_wr && avs_writedata[nand_host_pkg::CTRL_START])
        begin
          // quad refused while hardware protection is on
          if (fast && q.cmd.quad && q.cfg.wp_en)
          begin
            d.refused = 1'b1;
          end
          else
          begin
            d.dl = !fast ? nand_host_pkg::LANE_1 :
              (q.cmd.quad ? nand_host_pkg::LANE_4 : nand_host_pkg::LANE_2);
            // quad and 4-byte bits pick the fast read opcode
            unique case ({q.cmd.quad, q.cmd.addr4})
              2'b00: opc = nand_host_pkg::OP_DUAL_IO;
              2'b01: opc = nand_host_pkg::OP_DUAL_IO_4B;
              2'b10: opc = nand_host_pkg::OP_QUAD_IO;
              2'b11: opc = nand_host_pkg::OP_QUAD_IO_4B;
            endcase
            nab = q.cmd.addr4 ? nand_host_pkg::COL_BYTES_4 :
              nand_host_pkg::COL_BYTES_3;
            // extra access forces column and buffer dummies
            col = (!fast || bufm) ? q.addr : 24'h00_0000;
            d.dum = bufm ? q.cfg.dummy_buf : q.cfg.dummy_seq;
            // extra access toggled by software command
            // load and execute issued as plain commands
            // lock sequence issued as plain commands
            // freeze sequence issued as plain commands
            // protection fields written by earlier commands
            if (!fast)
            begin
              opc = q.cmd.opcode;
              nab = q.cmd.nabytes;
            end
            d.st = nand_host_pkg::S_OPC;
            d.cs_n = 1'b0;
            d.sh = opc;
            d.lane = nand_host_pkg::LANE_1;
            d.steps = 5'h08;
            d.nab = nab;
            d.a24 = align(col, nab);
            d.xf = fast;
            d.xw = !fast && q.cmd.wr;
            d.len = q.len_r;
            d.stream = fast && (q.len_r == 16'h0000);
            d.poll_ph = 1'b0;
            d.abt = 1'b0;
          end
        end
      end
      nand_host_pkg::S_OPC, nand_host_pkg::S_ADDR,
      nand_host_pkg::S_DUMMY, nand_host_pkg::S_TX,
      nand_host_pkg::S_RX:
      begin
        // Hold the clock low while a read byte is still unread
        if (tick && !q.sck && !(q.st == nand_host_pkg::S_RX
            && q.rx_valid && q.steps == bsteps(q.lane)))
        begin
          d.sck = 1'b1;
        end
        if (tick && q.sck)
        begin
          d.sck = 1'b0;
          d.shin = sin;
          d.steps = q.steps - 5'h01;
          case (q.lane)
            nand_host_pkg::LANE_1: d.sh = {q.sh[6:0], 1'b0};
            nand_host_pkg::LANE_2: d.sh = {q.sh[5:0], 2'b00};
            default: d.sh = {q.sh[3:0], 4'h0};
          endcase
          if (q.steps == 5'h01)
          begin
            if (q.st == nand_host_pkg::S_OPC
                || q.st == nand_host_pkg::S_ADDR)
            begin
              if (q.nab != 2'h0)
              begin
                d.st = nand_host_pkg::S_ADDR;
                d.lane = q.dl;
                d.sh = q.a24[23:16];
                d.a24 = {q.a24[15:0], 8'h00};
                d.nab = q.nab - 2'h1;
                d.steps = bsteps(q.dl);
              end
              else if (q.xf && q.dum != 5'h00)
              begin
                d.st = nand_host_pkg::S_DUMMY;
                d.lane = q.dl;
                d.sh = 8'h00;
                d.steps = q.dum;
              end
              else if (q.xf || q.poll_ph || (!q.xw && q.len != 16'h0000))
              begin
                d.st = nand_host_pkg::S_RX;
                d.lane = q.dl;
                d.steps = bsteps(q.dl);
              end
              else if (q.xw && q.len != 16'h0000)
              begin
                d.st = nand_host_pkg::S_TXW;
              end
              else
              begin
                d = to_gap(d);
              end
            end
            else if (q.st == nand_host_pkg::S_DUMMY)
            begin
              d.st = nand_host_pkg::S_RX;
              d.steps = bsteps(q.dl);
            end
            else if (q.st == nand_host_pkg::S_TX)
            begin
              d.len = q.len - 16'h0001;
              d.st = nand_host_pkg::S_TXW;
              if (q.len == 16'h0001)
              begin
                d = to_gap(d);
              end
            end
            else
            begin
              if (q.poll_ph)
              begin
                d.stat = sin;
              end
              else
              begin
                d.rxd = sin;
                d.rx_valid = 1'b1;
              end
              d.len = q.len - 16'h0001;
              d.steps = bsteps(q.lane);
              if (!q.stream && q.len == 16'h0001)
              begin
                d = to_gap(d);
              end
            end
          end
        end
      end
      nand_host_pkg::S_TXW:
      begin
        if (q.tx_full)
        begin
          d.st = nand_host_pkg::S_TX;
          d.sh = q.txd;
          d.tx_full = 1'b0;
          d.lane = nand_host_pkg::LANE_1;
          d.steps = 5'h08;
        end
      end
      nand_host_pkg::S_GAP:
      begin
        if (tick)
        begin
          d.gap = q.gap + 3'h1;
        end
        if (q.gap == nand_host_pkg::CS_GAP_TICKS)
        begin
          // buffer reads only after busy clears
          if (!q.abt && ((q.poll_ph && q.stat[nand_host_pkg::STAT_BUSY_BIT])
              || (!q.poll_ph && q.cmd.poll)))
          begin
            d.st = nand_host_pkg::S_OPC;
            d.cs_n = 1'b0;
            d.sh = q.poll.opcode;
            d.lane = nand_host_pkg::LANE_1;
            d.dl = nand_host_pkg::LANE_1;
            d.steps = 5'h08;
            d.nab = 2'h1;
            d.a24 = {q.poll.addr, 16'h0000};
            d.xf = 1'b0;
            d.xw = 1'b0;
            d.len = 16'h0001;
            d.stream = 1'b0;
            d.poll_ph = 1'b1;
          end
          else
          begin
            d.st = nand_host_pkg::S_IDLE;
            d.poll_ph = 1'b0;
            d.abt = 1'b0;
          end
        end
      end
    endcase

    // Abort ends any transfer and any polling, but is ignored in the select gap
    if (ctrl_wr && avs_writedata[nand_host_pkg::CTRL_ABORT]
        && q.st != nand_host_pkg::S_IDLE && q.st != nand_host_pkg::S_GAP)
    begin
      d = to_gap(d);
      d.abt = 1'b1;
    end

    // A software write wins over the engine taking the byte
    if (wen && avs_byteenable[0]
        && avs_address == nand_host_pkg::REG_TXDATA)
    begin
      d.txd = avs_writedata[7:0];
      d.tx_full = 1'b1;
    end

    // Pin drive from the next state
    drv = d.st inside {nand_host_pkg::S_OPC, nand_host_pkg::S_ADDR,
      nand_host_pkg::S_DUMMY, nand_host_pkg::S_TXW, nand_host_pkg::S_TX};
    if (d.st == nand_host_pkg::S_IDLE || d.st == nand_host_pkg::S_GAP)
    begin
      d.io_o = 4'h0;
      d.io_oe = 4'h0;
    end
    else
    begin
      case (d.lane)
        nand_host_pkg::LANE_1:
        begin
          d.io_o = {3'b110, d.sh[7]};
          d.io_oe = drv ? 4'hD : 4'hC;
        end
        nand_host_pkg::LANE_2:
        begin
          d.io_o = {2'b11, d.sh[7:6]};
          d.io_oe = drv ? 4'hF : 4'hC;
        end
        default:
        begin
          d.io_o = d.sh[7:4];
          d.io_oe = drv ? 4'hF : 4'h0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      q <= nand_host_pkg::HOST_RST;
    end
    else
    begin
      q <= d;
    end
  end

  assign avs_readdata = q.rdata;
  assign avs_waitrequest = q.wait_r;
  assign spi_cs_n = q.cs_n;
  assign spi_sck = q.sck;
  assign spi_io_o = q.io_o;
  assign spi_io_oe = q.io_oe;

endmodule

// [verification/nand_host_chk.sv]
// Port assertions for the serial NAND host
`timescale 1ns/1ns
module nand_host_chk (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Bus
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Pins
  input wire logic spi_cs_n,
  input wire logic spi_sck,
  input wire logic [3:0] spi_io_o,
  input wire logic [3:0] spi_io_oe
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_sck_hi;
    $rose(spi_sck) ##0 spi_sck [*4];
  endsequence
  a_bus_answer: assert property (s_req |=> !avs_waitrequest)
    else $error("bus answer late");
  a_bus_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("bus answer too long");
  a_rdata_hold: assert property (!(avs_read && avs_waitrequest)
    |=> $stable(avs_readdata))
    else $error("read data moved");
  a_idle_lines: assert property (spi_cs_n |-> !spi_sck && !spi_io_oe)
    else $error("pins active while deselected");
  a_sck_high: assert property (s_sck_hi |=> !spi_sck)
    else $error("serial clock high time wrong");
  a_io_steady: assert property (spi_sck |-> $stable(spi_io_o))
    else $error("data changed while clock high");
  a_cs_gap: assert property ($rose(spi_cs_n) |-> spi_cs_n [*8])
    else $error("select gap too short");
  a_cs_start: assert property ($fell(spi_cs_n) |-> spi_io_oe[0] [*8])
    else $error("opcode lane not driven");
endmodule

bind nand_host nand_host_chk u_nand_host_chk (
  .clk_sys(clk_sys), .reset_n(reset_n),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .spi_cs_n(spi_cs_n), .spi_sck(spi_sck),
  .spi_io_o(spi_io_o), .spi_io_oe(spi_io_oe)
);

// [verification/nand_dev_model.sv]
// Behavioural serial NAND device answering fast I/O reads
`timescale 1ns/1ns
module nand_dev_model #(
  parameter int BUF_BYTES = 2176
) (
  // Serial pins
  input wire logic cs_n,
  input wire logic sck,
  input wire logic [3:0] io,
  output logic [3:0] dout,
  output logic [7:0] op,
  // Mode set up by the bench
  input wire logic buf_fmt,
  input wire logic [4:0] dcyc
);
  logic [23:0] adr;
  logic [15:0] a;
  logic [7:0] b;
  int r;
  int k;
  wire [2:0] ln = op[6] ? 3'h4 : 3'h2;
  wire [4:0] ac = op[6] ? (op[2] ? 5'h06 : 5'h04) : (op[2] ? 5'h0C : 5'h08);
  initial
  begin
    dout = 4'h0;
    op = 8'h00;
    r = 0;
  end
  always @(negedge cs_n)
  begin
    r = 0;
    adr = 24'h00_0000;
  end
  always @(posedge sck)
  begin
    if (r < 8)
      op = {op[6:0], io[0]};
    else if (r < 8 + int'(ac))
      adr = op[6] ? {adr[19:0], io} : {adr[21:0], io[1:0]};
    r = r + 1;
  end
  always @(negedge sck or posedge cs_n)
  begin
    k = r - 8 - int'(ac) - int'(dcyc);
    a = (buf_fmt ? adr[15:0] : 16'h0000) + 16'(k / (8 / ln));
    b = (a[7:0] ^ 8'h3C) << ((k % (8 / ln)) * ln);
    if (cs_n || k < 0 || (buf_fmt && a >= BUF_BYTES))
      dout = ~dout;
    else
      dout = ln == 3'h4 ? b[7:4] : {~dout[3:2], b[7:6]};
  end
endmodule

// [verification/nand_host_tb.sv]
// Self-checking bench for the serial NAND host
`timescale 1ns/1ns
module nand_host_tb;
  typedef struct packed {
    logic quad;
    logic a4;
    logic bm;
    logic ex;
    logic [15:0] col;
    logic [7:0] b0;
    logic [7:0] b1;
  } row_t;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic spi_cs_n;
  logic spi_sck;
  logic [3:0] spi_io_o;
  logic [3:0] spi_io_oe;
  logic [3:0] spi_io_i;
  logic [3:0] dout;
  logic [7:0] op;
  logic [7:0] eop;
  logic buf_fmt = 1'b1;
  logic [4:0] dcyc = 5'h04;
  logic [31:0] q;
  int err_count = 0;
  int tests_run = 0;
  int falls = 0;
  int n;
  row_t rows [6] = '{36'h2_0123_1F18, 36'h6_0456_6A6B, 36'hA_0080_BCBD,
    36'hC_0555_3C3D, 36'h0_0777_3C3D, 36'h9_07FE_C2C3};
  assign spi_io_i = (spi_io_oe & spi_io_o) | (~spi_io_oe & dout);
  always #5 clk_sys = ~clk_sys;
  always @(negedge spi_cs_n) falls++;
  nand_host u_nand_host (
    .clk_sys(clk_sys), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .spi_cs_n(spi_cs_n), .spi_sck(spi_sck), .spi_io_o(spi_io_o),
    .spi_io_oe(spi_io_oe), .spi_io_i(spi_io_i)
  );
  nand_dev_model u_nand_dev_model (
    .cs_n(spi_cs_n), .sck(spi_sck), .io(spi_io_o), .dout(dout),
    .op(op), .buf_fmt(buf_fmt), .dcyc(dcyc)
  );
  task automatic test_done;
    if (err_count == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [5:0] ad, input logic [31:0] d);
    @(posedge clk_sys);
    avs_address <= ad;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic idle;
    do bus(1'b0, nand_host_pkg::REG_STATUS, 32'h0);
    while (q[0] !== 1'b0);
  endtask
  task automatic rx(input logic [7:0] e);
    do bus(1'b0, nand_host_pkg::REG_STATUS, 32'h0);
    while (q[2] !== 1'b1);
    bus(1'b0, nand_host_pkg::REG_RXDATA, 32'h0);
    chk({24'h0, q[7:0]}, {24'h0, e});
  endtask
  task automatic run(input row_t r, input logic wp, input logic [15:0] len);
    buf_fmt <= r.bm | r.ex;
    dcyc <= (r.bm | r.ex) ? 5'h04 : 5'h06;
    bus(1'b1, nand_host_pkg::REG_CFG, {19'h0, 10'h0C4, wp, r.ex, r.bm});
    bus(1'b1, nand_host_pkg::REG_ADDR, {16'h0, r.col});
    bus(1'b1, nand_host_pkg::REG_LEN, {16'h0, len});
    bus(1'b1, nand_host_pkg::REG_CMD, {18'h0, r.a4, r.quad, 12'h800});
    bus(1'b1, nand_host_pkg::REG_CTRL, 32'h0000_0001);
  endtask
  initial
  begin
    #500000;
    err_count++;
    test_done;
  end
  initial
  begin
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    foreach (rows[i])
    begin
      run(rows[i], 1'b0, 16'h0002);
      rx(rows[i].b0);
      rx(rows[i].b1);
      idle;
      eop = {rows[i].quad ? 4'hE : 4'hB, rows[i].a4 ? 4'hC : 4'hB};
      chk({24'h0, op}, {24'h0, eop});
    end
    n = falls;
    run(rows[2], 1'b1, 16'h0002);
    idle;
    bus(1'b0, nand_host_pkg::REG_STATUS, 32'h0);
    chk({31'h0, q[1]}, 32'h0000_0001);
    chk(falls, n);
    bus(1'b1, nand_host_pkg::REG_CTRL, 32'h0000_0002);
    bus(1'b0, nand_host_pkg::REG_STATUS, 32'h0);
    chk({31'h0, q[1]}, 32'h0);
    run(rows[0], 1'b1, 16'h0002);
    rx(rows[0].b0);
    rx(rows[0].b1);
    idle;
    run(rows[4], 1'b0, 16'h0000);
    rx(8'h3C);
    rx(8'h3D);
    rx(8'h3E);
    bus(1'b1, nand_host_pkg::REG_CTRL, 32'h0000_0004);
    idle;
    chk({31'h0, spi_cs_n}, 32'h0000_0001);
    bus(1'b1, nand_host_pkg::REG_CMD, 32'h0000_0006);
    bus(1'b1, nand_host_pkg::REG_CTRL, 32'h0000_0001);
    idle;
    chk({24'h0, op}, 32'h0000_0006);
    run(rows[0], 1'b0, 16'h0000);
    rx(rows[0].b0);
    reset_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk({26'h0, spi_cs_n, spi_sck, spi_io_oe}, 32'h0000_0020);
    reset_n <= 1'b1;
    bus(1'b0, nand_host_pkg::REG_CFG, 32'h0);
    chk(q, nand_host_pkg::CFG_RST);
    bus(1'b0, nand_host_pkg::REG_CMD, 32'h0);
    chk(q, nand_host_pkg::CMD_RST);
    bus(1'b0, nand_host_pkg::REG_POLL, 32'h0);
    chk(q, nand_host_pkg::POLL_RST);
    bus(1'b0, 6'h3C, 32'h0);
    chk(q, 32'h0);
    test_done;
  end
endmodule
